// ### drive_words_map.vh
// Bit positions, reset values and telegram codes for the drive status and control words
`ifndef DRIVE_WORDS_MAP_VH
`define DRIVE_WORDS_MAP_VH

`define WORD_W            16
`define TEL_W             10
`define TEL_STD1          10'h001
`define TEL_STD20         10'h014
`define TEL_AUX350        10'h15e

`define ST_READY_START    0
`define ST_READY          1
`define ST_OP_EN          2
`define ST_FAULT          3
`define ST_NO_COAST       4
`define ST_NO_FAST        5
`define ST_LOCKOUT        6
`define ST_ALARM          7
`define ST_SPD_TOL        8
`define ST_MASTER_REQ     9
`define ST_SPD_CMP        10
`define ST_LIMIT_N        11
`define ST_BRAKE_OPEN     12
`define ST_MOT_TEMP_N     13
`define ST_CW             14
`define ST_BIT15          15

`define PC_ON             0
`define PC_OP_EN          3
`define PC_FAULT_ACK      7

`define AX_FIXSP_LO       0
`define AX_FIXSP_HI       3
`define AX_DDS_LO         4
`define AX_DDS_HI         5
`define AX_TECH_EN        8
`define AX_DCBRK_EN       9
`define AX_DROOP          11
`define AX_TORQUE         12
`define AX_NO_EXT_FAULT   13
`define AX_CDS_HI         15

`define STATUS_RESET      16'h0030
`define AUX_RESET         16'h2000

`endif

// ### aux_word_decoder.v
// Decoder of the auxiliary control word into drive commands
`timescale 1ns/10ps
`include "drive_words_map.vh"
module aux_word_decoder (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [15:0] aux_word,
	input  wire        aux_active,
	output reg  [3:0]  fixed_setpoint_sel,
	output reg  [1:0]  drive_set_select,
	output reg         cds_upper,
	output reg         tech_ctrl_en,
	output reg         dc_brake_en,
	output reg         droop_en,
	output reg         torque_mode,
	output reg         ext_fault
);
	// Routings fall to default when telegram leaves; external fault held off
	always @(posedge clock) begin
		if (!rst_n || !aux_active) begin
			fixed_setpoint_sel <= 4'h0;
			drive_set_select   <= 2'h0;
			cds_upper          <= 1'b0;
			tech_ctrl_en       <= 1'b0;
			dc_brake_en        <= 1'b0;
			droop_en           <= 1'b0;
			torque_mode        <= 1'b0;
			ext_fault          <= 1'b0;
		end else begin
			fixed_setpoint_sel <= aux_word[`AX_FIXSP_HI:`AX_FIXSP_LO];
			drive_set_select   <= aux_word[`AX_DDS_HI:`AX_DDS_LO];
			tech_ctrl_en       <= aux_word[`AX_TECH_EN];
			dc_brake_en        <= aux_word[`AX_DCBRK_EN];
			droop_en           <= aux_word[`AX_DROOP];
			torque_mode        <= aux_word[`AX_TORQUE];
			ext_fault          <= ~aux_word[`AX_NO_EXT_FAULT];
			cds_upper          <= aux_word[`AX_CDS_HI];
		end
	end
	// Bits 6, 7, 10 and 14 are never looked at
endmodule

// ### drive_status_control_words.v
// Status word packer and auxiliary control word register for the drive
`timescale 1ns/10ps
`include "drive_words_map.vh"
// How it works
// - bit 0: powered, initialised, pulses locked
// - bit 1: on command, no fault and not locked out
// - bit 2: operation enabled, follows setpoint
// - bit 3: fault present, cleared by acknowledge
// - bits 4/5: no coast or quick stop
// - bit 6: switch-on locked out
// - bit 7: alarm present, no acknowledge
// - bit 8: speed deviation inside tolerance
// - bit 9: request master control
// - bit 10: speed at or above comparison
// - bit 11 low: limit reached
// - bit 12: holding brake commanded open
// - bit 13 low: motor overtemperature alarm
// - bit 14: actual speed positive
// - entering telegram 20 switches bit 15 to the lower command set bit
// - aux bits 0-3 select fixed setpoint
// - aux bits 4-5 select drive set
// - aux bit 11 enables droop
// - aux bit 12 selects torque control
// - aux bit 13 low raises external fault
// - aux bit 15 upper command set bit
// - leaving telegram 350 clears routings
module drive_status_control_words (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [9:0]  telegram_sel,
	input  wire        aux_word_we,
	input  wire [15:0] aux_word_in,
	input  wire [15:0] primary_control_word,
	input  wire        supply_ok,
	input  wire        init_done,
	input  wire        pulses_locked,
	input  wire        fault_event,
	input  wire        coast_stop_active,
	input  wire        fast_stop_active,
	input  wire        alarm_active,
	input  wire        speed_in_tol,
	input  wire        master_ctrl_req,
	input  wire        speed_ge_cmp,
	input  wire        limit_reached,
	input  wire        brake_open_cmd,
	input  wire        motor_overtemp,
	input  wire        speed_positive,
	input  wire        inv_overload,
	input  wire        cds_lower,
	output reg  [15:0] drive_status_word_one,
	output reg  [15:0] aux_control_word_three,
	output reg         telegram20_active_r,
	output wire [3:0]  fixed_setpoint_sel,
	output wire [1:0]  drive_set_select,
	output wire        cds_upper,
	output wire        tech_ctrl_en,
	output wire        dc_brake_en,
	output wire        droop_en,
	output wire        torque_mode,
	output wire        ext_fault
);
	reg         fault_r;
	reg         lockout_r;
	reg         ack_prev_r;
	reg  [9:0]  layout_tel_r;
	reg  [15:0] status_nxt;
	wire        ack_rise;
	wire        on_cmd;
	wire        aux_active;

	assign on_cmd     = primary_control_word[`PC_ON];
	assign ack_rise   = primary_control_word[`PC_FAULT_ACK] & ~ack_prev_r;
	assign aux_active = (telegram_sel == `TEL_AUX350);

	// Fault latch: a new event beats an acknowledge in the same cycle
	always @(posedge clock) begin
		if (!rst_n) begin
			fault_r    <= 1'b0;
			lockout_r  <= 1'b0;
			ack_prev_r <= 1'b0;
		end else begin
			ack_prev_r <= primary_control_word[`PC_FAULT_ACK];
			if (fault_event)
				fault_r <= 1'b1;
			else if (ack_rise)
				fault_r <= 1'b0;
			// Lockout after acknowledge with on still set, until on drops
			if (ack_rise && fault_r && on_cmd)
				lockout_r <= 1'b1;
			else if (!on_cmd)
				lockout_r <= 1'b0;
		end
	end

	// layout_tel_r holds the last telegram other than telegram 20
	always @(posedge clock) begin
		if (!rst_n) begin
			layout_tel_r        <= `TEL_STD1;
			telegram20_active_r <= 1'b0;
		end else begin
			telegram20_active_r <= (telegram_sel == `TEL_STD20);
			if (telegram_sel != `TEL_STD20)
				layout_tel_r <= telegram_sel;
		end
	end

	// Pack the status word from the live drive states
	always @* begin
		status_nxt = 16'h0000;
		status_nxt[`ST_READY_START] = supply_ok & init_done & pulses_locked;
		status_nxt[`ST_READY]       = on_cmd & ~fault_r & ~lockout_r;
		status_nxt[`ST_OP_EN]       = on_cmd & ~fault_r & primary_control_word[`PC_OP_EN];
		status_nxt[`ST_FAULT]       = fault_r;
		status_nxt[`ST_NO_COAST]    = ~coast_stop_active;
		status_nxt[`ST_NO_FAST]     = ~fast_stop_active;
		status_nxt[`ST_LOCKOUT]     = lockout_r;
		status_nxt[`ST_ALARM]       = alarm_active;
		status_nxt[`ST_SPD_TOL]     = speed_in_tol;
		status_nxt[`ST_MASTER_REQ]  = master_ctrl_req;
		status_nxt[`ST_SPD_CMP]     = speed_ge_cmp;
		status_nxt[`ST_LIMIT_N]     = ~limit_reached;
		status_nxt[`ST_BRAKE_OPEN]  = brake_open_cmd;
		status_nxt[`ST_MOT_TEMP_N]  = ~motor_overtemp;
		status_nxt[`ST_CW]          = speed_positive;
		// Bit 15 shows cds_lower in telegram 20, otherwise no inverter overload
		if (telegram_sel == `TEL_STD20 && layout_tel_r == `TEL_STD20)
			status_nxt[`ST_BIT15] = cds_lower;
		else if (telegram_sel == `TEL_STD20)
			status_nxt[`ST_BIT15] = cds_lower;
		else
			status_nxt[`ST_BIT15] = ~inv_overload;
	end

	// Registered status word and aux control word storage
	always @(posedge clock) begin
		if (!rst_n) begin
			drive_status_word_one  <= `STATUS_RESET;
			aux_control_word_three <= `AUX_RESET;
		end else begin
			drive_status_word_one <= status_nxt;
			// Leaving the aux telegram restores the safe default
			if (!aux_active)
				aux_control_word_three <= `AUX_RESET;
			else if (aux_word_we)
				aux_control_word_three <= aux_word_in;
		end
	end

	// Command decoding lives in its own module
	aux_word_decoder u_dec (
		.clock              (clock),
		.rst_n              (rst_n),
		.aux_word           (aux_control_word_three),
		.aux_active         (aux_active),
		.fixed_setpoint_sel (fixed_setpoint_sel),
		.drive_set_select   (drive_set_select),
		.cds_upper          (cds_upper),
		.tech_ctrl_en       (tech_ctrl_en),
		.dc_brake_en        (dc_brake_en),
		.droop_en           (droop_en),
		.torque_mode        (torque_mode),
		.ext_fault          (ext_fault)
	);
endmodule

// ### fieldbus_master.sv
// Behavioural fieldbus master that drives the control words
`timescale 1ns/10ps
module fieldbus_master (
	input  wire         clock,
	output logic [15:0] primary_control_word,
	output logic [15:0] aux_word_in,
	output logic        aux_word_we
);
	// Idle with no external fault flagged
	initial begin
		primary_control_word = 16'h0000;
		aux_word_in = 16'h2000;
		aux_word_we = 1'b0;
	end
	// Acknowledge is given as a rising edge on bit 7
	task ctl(input logic [15:0] w);
		primary_control_word = w;
	endtask
	// One write; afterwards the data shows the inverse so stale data never passes
	task send_aux(input logic [15:0] w);
		aux_word_in = w;
		aux_word_we = 1'b1;
		@(posedge clock) #1;
		aux_word_we = 1'b0;
		aux_word_in = ~w;
	endtask
endmodule

// ### drive_words_chk.sv
// Concurrent checks on the status and control word ports
`timescale 1ns/10ps
module drive_words_chk (
	input logic        clock, rst_n, aux_word_we, supply_ok, init_done, pulses_locked, fault_event,
	input logic        coast_stop_active, fast_stop_active, alarm_active, speed_in_tol, master_ctrl_req,
	input logic        speed_ge_cmp, limit_reached, brake_open_cmd, motor_overtemp, speed_positive,
	input logic        cds_upper, tech_ctrl_en, dc_brake_en, droop_en, torque_mode, ext_fault,
	input logic [9:0]  telegram_sel,
	input logic [15:0] aux_word_in, primary_control_word, drive_status_word_one, aux_control_word_three,
	input logic [3:0]  fixed_setpoint_sel,
	input logic [1:0]  drive_set_select
);
	logic        live_r;
	logic [15:0] aux_p_r;
	wire  [15:0] st = drive_status_word_one;
	wire  [10:0] dv = {cds_upper, torque_mode, droop_en, dc_brake_en, tech_ctrl_en, drive_set_select, fixed_setpoint_sel};
	wire         wr = aux_word_we && telegram_sel == 10'h15e;
	// First edge out of reset still shows reset values, so status checks wait one edge
	// Stored word one edge back, which the decoder outputs follow
	always @(posedge clock) begin
		live_r  <= rst_n;
		aux_p_r <= aux_control_word_three;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_ready_start: assert property (live_r |-> st[0] == $past(supply_ok && init_done && pulses_locked))
		else $error("ready bit wrong");
	a_stop_flags: assert property (live_r |-> st[5:4] == ~$past({fast_stop_active, coast_stop_active}))
		else $error("stop flags wrong");
	a_copy_flags: assert property (live_r |-> {st[14], st[12], st[10:7]} == $past({speed_positive, brake_open_cmd,
		speed_ge_cmp, master_ctrl_req, speed_in_tol, alarm_active}))
		else $error("copied flags wrong");
	a_low_flags: assert property (live_r |-> {st[13], st[11]} == ~$past({motor_overtemp, limit_reached}))
		else $error("low flags wrong");
	a_fault_sets: assert property (fault_event |-> ##[1:2] st[3])
		else $error("fault not shown");
	a_op_cause: assert property (live_r && st[2] |-> $past(primary_control_word[3] && primary_control_word[0]))
		else $error("operation without enable");
	a_aux_store: assert property (wr |=> aux_control_word_three == $past(aux_word_in))
		else $error("aux word not stored");
	a_aux_decode: assert property (live_r && $past(telegram_sel == 10'h15e) |-> dv == {aux_p_r[15], aux_p_r[12],
		aux_p_r[11], aux_p_r[9:8], aux_p_r[5:0]} && ext_fault == !aux_p_r[13])
		else $error("aux decode wrong");
	a_leave_clear: assert property ((telegram_sel != 10'h15e) [*2] |=> aux_control_word_three == 16'h2000
		&& dv == 11'h000 && !ext_fault)
		else $error("routings not cleared");
	c_write: cover property (wr);
	c_lockout: cover property (st[6]);
	c_tel20: cover property (telegram_sel == 10'h014 && st[15]);
endmodule
bind drive_status_control_words drive_words_chk u_chk (.*);

// ### drive_status_control_words_test.sv
// Self-checking bench for the status and control word block
`timescale 1ns/10ps
module drive_status_control_words_test;
	logic        clock, rst_n, fault_event;
	logic [9:0]  telegram_sel;
	logic [14:0] v;
	wire  [15:0] primary_control_word, aux_word_in, st, aux;
	wire         aux_word_we, t20, cu, te, db, dr, tq, ef;
	wire  [3:0]  fs;
	wire  [1:0]  ds;
	wire  [15:0] dv = {4'h0, cu, tq, dr, db, te, ds, fs, ef};
	int          bad_count, samples_checked, cyc, i;
	logic [15:0] rows [5][2] = '{'{16'h0000, 16'ha830}, '{16'h7fff, 16'h5781}, '{16'h6000, 16'ha830},
		'{16'h5555, 16'hfd10}, '{16'h2aaa, 16'h02a0}};
	fieldbus_master pm (.*);
	drive_status_control_words DUT (.supply_ok(v[14]), .init_done(v[13]), .pulses_locked(v[12]),
		.coast_stop_active(v[11]), .fast_stop_active(v[10]), .alarm_active(v[9]), .speed_in_tol(v[8]),
		.master_ctrl_req(v[7]), .speed_ge_cmp(v[6]), .limit_reached(v[5]), .brake_open_cmd(v[4]),
		.motor_overtemp(v[3]), .speed_positive(v[2]), .inv_overload(v[1]), .cds_lower(v[0]),
		.drive_status_word_one(st), .aux_control_word_three(aux), .telegram20_active_r(t20),
		.fixed_setpoint_sel(fs), .drive_set_select(ds), .cds_upper(cu), .tech_ctrl_en(te),
		.dc_brake_en(db), .droop_en(dr), .torque_mode(tq), .ext_fault(ef), .*);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Hang guard, far above the 69 cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			end_sim;
		end
	end
	initial begin
		rst_n = 1'b0;
		fault_event = 1'b0;
		telegram_sel = 10'h001;
		v = 15'h0000;
		tick(3);
		chk(st, 16'h0030);
		chk(aux, 16'h2000);
		rst_n = 1'b1;
		for (i = 0; i < 5; i++) begin
			v = rows[i][0][14:0];
			tick(2);
			chk(st, rows[i][1]);
		end
		$display("status table done");
		// Start, run, fault, acknowledge with on still set, then drop on
		v = 15'h7000;
		pm.ctl(16'h0001);
		tick(3);
		chk({10'h0, st[6:1]}, 16'h0019);
		pm.ctl(16'h0009);
		tick(3);
		chk({10'h0, st[6:1]}, 16'h001b);
		fault_event = 1'b1;
		tick(1);
		fault_event = 1'b0;
		tick(2);
		chk({10'h0, st[6:1]}, 16'h001c);
		pm.ctl(16'h0081);
		tick(3);
		chk({10'h0, st[6:1]}, 16'h0038);
		pm.ctl(16'h0000);
		tick(3);
		chk({10'h0, st[6:1]}, 16'h0018);
		$display("state sequence done");
		telegram_sel = 10'h014;
		v = 15'h0001;
		tick(3);
		chk({15'h0, st[15]}, 16'h0001);
		chk({15'h0, t20}, 16'h0001);
		$display("telegram 20 done");
		// Write refused outside the aux telegram, then every setpoint code
		telegram_sel = 10'h001;
		pm.send_aux(16'hffff);
		tick(1);
		chk(aux, 16'h2000);
		telegram_sel = 10'h15e;
		tick(1);
		for (i = 0; i < 16; i++) begin
			pm.send_aux({4{i[3:0]}});
			tick(1);
			chk(aux, {4{i[3:0]}});
			chk(dv, {4'h0, i[3], i[0], i[3], i[1], i[0], i[1:0], i[3:0], ~i[1]});
		end
		telegram_sel = 10'h001;
		tick(3);
		chk(aux, 16'h2000);
		chk(dv, 16'h0000);
		$display("aux word done");
		end_sim;
	end
endmodule
